// File: verilog/mac_engine.sv
// Single-cycle 16x16 multiply-accumulate engine with 41-bit accumulator.
// Assumes a plain byte register port and a DMA controller on core_clk.
`timescale 1ns/1ps
module mac_engine
    import mac_pkg::*;
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    // Register port
    input  wire logic [3:0]   reg_addr,
    input  wire logic [7:0]   reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic      [7:0]   reg_rdata,
    // DMA side
    input  wire logic         dma_chan_en,
    input  wire mac_dma_in_s  dma_in,
    output mac_dma_req_s      dma_req
);
    // ==========================================================
    // State
    logic [7:0]      cfg0_q, cfg1_q, cfg2_q;   // Configuration registers
    logic [7:0]      iter_q, iter_cnt_q;       // Iterations and countdown
    logic            clr_q;                    // Pending accumulator clear
    logic            busy_q;                   // Busy / start
    logic [4:0]      flags_q, flags_d;         // Status flags
    logic [15:0]     opa_q, opb_q;             // Operands
    logic [40:0]     acc_q;                    // Accumulator
    logic [7:0]      rdata_q;                  // Read data
    mac_dstate_e     st_q;                     // DMA sequencer
    logic            a_lo_q, a_done_q;         // First operand bytes seen
    logic            b_lo_q, b_done_q;         // Second operand bytes seen
    logic [2:0]      accb_q;                   // Accumulator bytes loaded
    // ==========================================================
    // Decodes
    logic sgn, accsel, frac, a_blk, dma_mode, mcu_exec, exec, fin, part;
    logic st_wr;
    logic [2:0] acclen;
    assign sgn      = cfg0_q[CF0_SIGNED];
    assign accsel   = cfg0_q[CF0_ACCSEL];
    assign frac     = cfg0_q[CF0_FRAC];
    assign a_blk    = cfg2_q[CF2_AINC] | cfg2_q[CF2_ASRC];
    // Lengths above five bytes still load only the five byte lanes
    assign acclen   = (cfg2_q[CF2_ACCLEN +: 3] > ACC_BYTES) ? ACC_BYTES
                                                            : cfg2_q[CF2_ACCLEN +: 3];
    assign st_wr    = reg_wr && (reg_addr == OFS_STAT);
    assign dma_mode = dma_chan_en;
    assign mcu_exec = busy_q && !dma_mode && (st_q == DS_IDLE);
    assign exec     = mcu_exec || (st_q == DS_EXEC);
    assign fin      = mcu_exec || ((st_q == DS_EXEC) && (iter_cnt_q <= 8'h01));

    // Sign or zero fill of a value above bit pos
    function automatic logic [40:0] fill41(input logic [40:0] v, input int pos,
                                           input logic s);
        logic [40:0] r;
        r = v;
        for (int i = 0; i < ACCW; i++)
            if (i > pos)
                r[i] = s & v[pos];
        return r;
    endfunction : fill41

    // ==========================================================
    // Arithmetic path
    logic signed [16:0] a_ext, b_ext;
    logic signed [33:0] prod;
    logic        [41:0] prod42, addend, sum;
    logic        [40:0] new_acc;
    logic               hard_overflow_flag_ev, sovf_ev;
    assign a_ext  = {sgn & opa_q[15], opa_q};
    assign b_ext  = {sgn & opb_q[15], opb_q};
    assign prod   = a_ext * b_ext;
    assign prod42 = frac ? {{7{prod[33]}}, prod, 1'b0} : {{8{prod[33]}}, prod};
    assign addend = (accsel || clr_q) ? 42'h000_0000_0000 : {sgn & acc_q[40], acc_q};
    assign sum    = addend + prod42;
    assign new_acc = sum[40:0];
    assign hard_overflow_flag_ev = sgn ? (sum[41] ^ sum[40]) : sum[41];
    assign sovf_ev = sgn ? (sum[40] ^ sum[39]) : sum[40];

    // ==========================================================
    // Configuration registers
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg0_q <= CFG_RST;
            cfg1_q <= CFG_RST;
            cfg2_q <= CFG_RST;
            iter_q <= ITER_RST;
        end
        else if (reg_wr)
        begin
            // Clear bit is held apart, never stored here
            case (reg_addr)
                OFS_CFG0: cfg0_q <= reg_wdata & ~(8'h01 << CF0_CLR);
                OFS_CFG1: cfg1_q <= reg_wdata;
                OFS_CFG2: cfg2_q <= reg_wdata;
                OFS_ITER: iter_q <= reg_wdata;
                default:  ;
            endcase
        end
    end

    // ==========================================================
    // Self-clearing accumulator clear
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            clr_q <= 1'b0;
        else
            clr_q <= reg_wr && (reg_addr == OFS_CFG0) && reg_wdata[CF0_CLR];
    end

    // ==========================================================
    // Busy bit: software sets, hardware clears, set wins
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            busy_q <= 1'b0;
        else if (st_wr && reg_wdata[ST_BUSY])
            busy_q <= 1'b1;
        else if (fin || part)
            busy_q <= 1'b0;
    end

    // ==========================================================
    // Status flags; writing zero clears a flag, events win
    always_comb
    begin
        flags_d = flags_q;
        if (clr_q)
            flags_d = 5'h00;
        if (st_wr)
            flags_d = flags_d & reg_wdata[4:0];
        if (exec)
        begin
            // hard overflow only in accumulate mode
            if (!accsel && hard_overflow_flag_ev)
                flags_d[ST_HARD_OVERFLOW_FLAG] = 1'b1;
            if (sovf_ev)
                flags_d[ST_SOVF] = 1'b1;
            flags_d[ST_ZERO] = (new_acc == 41'h0);
        end
        if (fin)
        begin
            flags_d[ST_INT] = 1'b1;
            flags_d[ST_RDY] = 1'b1;
        end
    end
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            flags_q <= 5'h00;
        else
            flags_q <= flags_d;
    end

    // ==========================================================
    // DMA sequencer
    logic dma_a, dma_b, dma_c;
    assign dma_a = dma_in.valid && (dma_in.tgt == TGT_A);
    assign dma_b = dma_in.valid && (dma_in.tgt == TGT_B);
    assign dma_c = dma_in.valid && (dma_in.tgt == TGT_ACC);
    // source ran dry inside a multi-byte unit
    assign part  = ((st_q == DS_OPS) && ((dma_a && !a_lo_q) || (dma_b && !b_lo_q))
                   && dma_in.last)
                || ((st_q == DS_ACCLD) && dma_c && dma_in.last && (accb_q + 3'h1 < acclen));
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q       <= DS_IDLE;
            a_lo_q     <= 1'b0;
            a_done_q   <= 1'b0;
            b_lo_q     <= 1'b0;
            b_done_q   <= 1'b0;
            accb_q     <= 3'h0;
            iter_cnt_q <= 8'h00;
        end
        else if (part || !busy_q || !dma_mode)
        begin
            st_q     <= DS_IDLE;
            a_lo_q   <= 1'b0;
            b_lo_q   <= 1'b0;
            accb_q   <= 3'h0;
        end
        else
        begin
            case (st_q)
                DS_IDLE:
                begin
                    // constant first operand is never fetched
                    a_done_q   <= a_blk;
                    b_done_q   <= 1'b0;
                    iter_cnt_q <= iter_q;
                    st_q       <= (acclen != 3'h0) ? DS_ACCLD : DS_OPS;
                end
                DS_ACCLD:
                begin
                    if (dma_c)
                    begin
                        accb_q <= accb_q + 3'h1;
                        if (accb_q + 3'h1 >= acclen)
                            st_q <= DS_OPS;
                    end
                end
                DS_OPS:
                begin
                    if (dma_a)
                    begin
                        a_lo_q   <= !a_lo_q;
                        a_done_q <= a_lo_q;
                    end
                    if (dma_b)
                    begin
                        b_lo_q   <= !b_lo_q;
                        b_done_q <= b_lo_q;
                    end
                    if (a_done_q && b_done_q)
                        st_q <= DS_EXEC;
                end
                DS_EXEC:
                begin
                    iter_cnt_q <= iter_cnt_q - 8'h01;
                    a_done_q   <= a_blk;
                    b_done_q   <= 1'b0;
                    st_q       <= DS_OPS;
                end
                default: st_q <= DS_IDLE;
            endcase
        end
    end

    // requests gated by busy and phase
    always_comb
    begin
        dma_req.acc = busy_q && dma_mode && (st_q == DS_ACCLD);
        dma_req.a   = busy_q && dma_mode && (st_q == DS_OPS) && !a_done_q && !a_blk;
        dma_req.b   = busy_q && dma_mode && (st_q == DS_OPS) && !b_done_q;
    end

    // ==========================================================
    // Operand registers
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            opa_q <= 16'h0000;
            opb_q <= 16'h0000;
        end
        else
        begin
            if (reg_wr && reg_addr == OFS_AL) opa_q[7:0]  <= reg_wdata;
            if (reg_wr && reg_addr == OFS_AH) opa_q[15:8] <= reg_wdata;
            if (reg_wr && reg_addr == OFS_BL) opb_q[7:0]  <= reg_wdata;
            if (reg_wr && reg_addr == OFS_BH) opb_q[15:8] <= reg_wdata;
            // DMA bytes arrive low byte first
            if (st_q == DS_OPS && dma_a)
                if (a_lo_q) opa_q[15:8] <= dma_in.data;
                else        opa_q[7:0]  <= dma_in.data;
            if (st_q == DS_OPS && dma_b)
                if (b_lo_q) opb_q[15:8] <= dma_in.data;
                else        opb_q[7:0]  <= dma_in.data;
            // Auto-increment after each DMA operation
            if (st_q == DS_EXEC && cfg2_q[CF2_AINC])
                opa_q <= opa_q + 16'h0001;
        end
    end

    // ==========================================================
    // Accumulator
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            acc_q <= 41'h0;
        else if (exec)
            acc_q <= new_acc;
        else if (clr_q)
            acc_q <= 41'h0;
        // short load zero or sign fills above
        else if (st_q == DS_ACCLD && dma_c)
        begin
            if (accb_q == 3'h0)
                acc_q <= fill41({33'h0, dma_in.data}, 7, sgn);
            else
                acc_q <= fill41((acc_q & ~(41'hFF << (8 * accb_q)))
                                | ({33'h0, dma_in.data} << (8 * accb_q)),
                                8 * int'(accb_q) + 7, sgn);
        end
        else if (reg_wr && reg_addr >= OFS_ACC0 && reg_addr <= OFS_ACC3)
            acc_q[8 * (reg_addr - OFS_ACC0) +: 8] <= reg_wdata;
        else if (reg_wr && reg_addr == OFS_OVR)
            acc_q[40:32] <= {sgn & reg_wdata[7], reg_wdata};
    end

    // ==========================================================
    // Read view: rounding, saturation, alignment
    logic [40:0] rnd, sat, view;
    assign rnd = cfg1_q[CF1_RND] ? ((acc_q + RND_HALF) & ~41'h000_0000_FFFF) : acc_q;
    always_comb
    begin
        sat = rnd;
        if (cfg1_q[CF1_SAT] && sgn && (rnd[40] ^ rnd[39]))
            sat = rnd[40] ? {2'b11, 39'h0} : SAT_POS;
        else if (cfg1_q[CF1_SAT] && !sgn && rnd[40])
            sat = {1'b0, {40{1'b1}}};
        case (cfg1_q[CF1_ALN +: 2])
            2'h1:    view = fill41(sat >> 8, 32, sgn);
            2'h2:    view = fill41(sat >> 24, 16, sgn);
            2'h3:    view = fill41(sat >> 32, 8, sgn);
            default: view = sat;
        endcase
    end

    // forty readable bits in five bytes
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_q <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                OFS_CFG0: rdata_q <= cfg0_q | {2'b00, clr_q, 5'h00};
                OFS_CFG1: rdata_q <= cfg1_q;
                OFS_CFG2: rdata_q <= cfg2_q;
                OFS_STAT: rdata_q <= {busy_q, 2'b00, flags_q};
                OFS_AL:   rdata_q <= opa_q[7:0];
                OFS_AH:   rdata_q <= opa_q[15:8];
                OFS_BL:   rdata_q <= opb_q[7:0];
                OFS_BH:   rdata_q <= opb_q[15:8];
                4'h8:     rdata_q <= view[7:0];
                4'h9:     rdata_q <= view[15:8];
                4'hA:     rdata_q <= view[23:16];
                OFS_ACC3: rdata_q <= view[31:24];
                OFS_OVR:  rdata_q <= view[39:32];
                OFS_ITER: rdata_q <= iter_q;
                default:  rdata_q <= 8'h00;
            endcase
        end
        else
            rdata_q <= 8'h00;
    end
    assign reg_rdata = rdata_q;

    // ==========================================================
    // Assertions
    // busy drops the cycle after a processor start
    property p_mcu_done;
        @(posedge core_clk) disable iff (sys_rst)
        (mcu_exec && !(st_wr && reg_wdata[ST_BUSY])) |=> !busy_q;
    endproperty
    a_mcu_done: assert property (p_mcu_done) else $error("busy not cleared");
    property p_flags_set;
        @(posedge core_clk) disable iff (sys_rst)
        fin |=> flags_q[ST_INT] && flags_q[ST_RDY];
    endproperty
    a_flags_set: assert property (p_flags_set) else $error("done flags missing");
    property p_clear;
        @(posedge core_clk) disable iff (sys_rst)
        (clr_q && !exec && !(reg_wr && (reg_addr == OFS_CFG0) && reg_wdata[CF0_CLR]))
            |=> (acc_q == 41'h0) && !clr_q && (flags_q == 5'h00);
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");
    // accumulate adds product to old value
    property p_accum;
        @(posedge core_clk) disable iff (sys_rst)
        (exec && !accsel && !clr_q) |=> acc_q == $past(acc_q) + $past(prod42[40:0]);
    endproperty
    a_accum: assert property (p_accum) else $error("accumulate wrong");
    property p_mulonly;
        @(posedge core_clk) disable iff (sys_rst)
        (exec && accsel) |=> acc_q == $past(prod42[40:0]);
    endproperty
    a_mulonly: assert property (p_mulonly) else $error("overwrite wrong");
    property p_hard_overflow_flag_keep;
        @(posedge core_clk) disable iff (sys_rst)
        (exec && accsel && !clr_q && !st_wr) |=> $stable(flags_q[ST_HARD_OVERFLOW_FLAG]);
    endproperty
    a_hard_overflow_flag_keep: assert property (p_hard_overflow_flag_keep) else $error("hard_overflow_flag changed");
    // requests only while busy in DMA mode
    property p_req_busy;
        @(posedge core_clk) disable iff (sys_rst)
        (dma_req.a || dma_req.b || dma_req.acc) |-> busy_q && dma_chan_en;
    endproperty
    a_req_busy: assert property (p_req_busy) else $error("request while idle");
    // no first operand request when blocked
    property p_a_block;
        @(posedge core_clk) disable iff (sys_rst)
        a_blk |-> !dma_req.a;
    endproperty
    a_a_block: assert property (p_a_block) else $error("blocked request");
    property p_partial;
        @(posedge core_clk) disable iff (sys_rst)
        (part && !(st_wr && reg_wdata[ST_BUSY])) |=> !busy_q ##1 (st_q == DS_IDLE);
    endproperty
    a_partial: assert property (p_partial) else $error("partial not ended");
    c_mcu: cover property (@(posedge core_clk) disable iff (sys_rst) mcu_exec);
    c_dma: cover property (@(posedge core_clk) disable iff (sys_rst)
                           (st_q == DS_EXEC) ##1 (st_q == DS_OPS));
    c_part: cover property (@(posedge core_clk) disable iff (sys_rst) part);
endmodule : mac_engine

// File: verilog/mac_pkg.sv
// Shared constants and carriers for the multiply-accumulate engine.
// Assumes an 8-bit register port and a byte-wide DMA write channel.
package mac_pkg;
    // ==========================================================
    // Widths
    localparam int OPW  = 16;                 // Operand width
    localparam int ACCW = 41;                 // Internal accumulator width
    localparam int SUMW = 42;                 // Adder width with carry
    // ==========================================================
    // Register offsets (4-bit address)
    localparam logic [3:0] OFS_CFG0  = 4'h0;  // engine_config_0
    localparam logic [3:0] OFS_CFG1  = 4'h1;  // engine_config_1
    localparam logic [3:0] OFS_CFG2  = 4'h2;  // engine_config_2
    localparam logic [3:0] OFS_STAT  = 4'h3;  // engine_status
    localparam logic [3:0] OFS_AL    = 4'h4;  // operand_first low
    localparam logic [3:0] OFS_AH    = 4'h5;  // operand_first high
    localparam logic [3:0] OFS_BL    = 4'h6;  // operand_second low
    localparam logic [3:0] OFS_BH    = 4'h7;  // operand_second high
    localparam logic [3:0] OFS_ACC0  = 4'h8;  // acc_byte_0 .. acc_byte_3 at 8..B
    localparam logic [3:0] OFS_ACC3  = 4'hB;  // acc_byte_3
    localparam logic [3:0] OFS_OVR   = 4'hC;  // acc_overflow_byte
    localparam logic [3:0] OFS_ITER  = 4'hD;  // iteration_count
    // ==========================================================
    // Field positions
    localparam int CF0_SIGNED = 2;            // signed_select
    localparam int CF0_ACCSEL = 3;            // accumulate_select
    localparam int CF0_FRAC   = 4;            // fraction_select
    localparam int CF0_CLR    = 5;            // acc_clear
    localparam int CF1_RND    = 0;            // rounding_enable
    localparam int CF1_SAT    = 1;            // Saturation enable
    localparam int CF1_ALN    = 2;            // Alignment field, 2 bits
    localparam int CF2_AINC   = 0;            // first_operand_autoinc
    localparam int CF2_ASRC   = 1;            // first_operand_alt_source
    localparam int CF2_ACCLEN = 4;            // acc_dma_load_length, 3 bits
    localparam int ST_HARD_OVERFLOW_FLAG    = 0;            // hard_overflow_flag
    localparam int ST_SOVF    = 1;            // Soft overflow flag
    localparam int ST_ZERO    = 2;            // Zero result flag
    localparam int ST_RDY     = 3;            // acc_ready_flag
    localparam int ST_INT     = 4;            // done_interrupt_flag
    localparam int ST_BUSY    = 7;            // Busy / start bit
    // ==========================================================
    // Reset values and fixed figures
    localparam logic [7:0]  CFG_RST   = 8'h00;
    localparam logic [7:0]  ITER_RST  = 8'h00;
    localparam logic [2:0]  ACC_BYTES = 3'h5; // Full accumulator load
    localparam logic [40:0] RND_HALF  = 41'h000_0000_8000;
    localparam logic [40:0] SAT_POS   = 41'h07F_FFFF_FFFF; // Largest signed value
    // ==========================================================
    // DMA sequencer states
    typedef enum logic [1:0] {
        DS_IDLE  = 2'b00,
        DS_ACCLD = 2'b01,
        DS_OPS   = 2'b10,
        DS_EXEC  = 2'b11
    } mac_dstate_e;
    // DMA byte targets
    localparam logic [1:0] TGT_A   = 2'h0;
    localparam logic [1:0] TGT_B   = 2'h1;
    localparam logic [1:0] TGT_ACC = 2'h2;
    // DMA write beat into the engine
    typedef struct packed {
        logic       valid;
        logic [1:0] tgt;
        logic [7:0] data;
        logic       last;
    } mac_dma_in_s;
    // DMA request lines out of the engine
    typedef struct packed {
        logic acc;
        logic a;
        logic b;
    } mac_dma_req_s;
endpackage : mac_pkg

// File: sim/mac_dma_model.sv
// DMA controller stand-in: answers engine requests with operand bytes.
// Assumes the engine's byte beat carrier on core_clk.
`timescale 1ns/1ps
module mac_dma_model
    import mac_pkg::*;
#(
    parameter logic [15:0] A_VAL   = 16'h0002,         // First operand array entry
    parameter logic [15:0] B_VAL   = 16'h0003,         // Second operand array entry
    parameter logic [39:0] ACC_VAL = 40'h00_0000_8001  // Accumulator start value
)(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    // Test control
    input  wire logic         cut_a,     // First operand source runs dry
    // Engine side
    input  wire mac_dma_req_s dma_req,
    output mac_dma_in_s       dma_in
);
    logic hi_a_q;  // Next first operand byte is the high one
    logic hi_b_q;  // Next second operand byte is the high one
    logic [2:0] acc_i_q;  // Next accumulator byte lane
    // ==========================================================
    // one shared channel: accumulator first, then first operand, then second operand
    // Beat only on request, at most every other cycle; idle data toggles
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dma_in <= '0;
            hi_a_q <= 1'b0;
            hi_b_q <= 1'b0;
            acc_i_q <= 3'h0;
        end
        else if (!dma_in.valid && dma_req.acc)
        begin
            dma_in  <= '{1'b1, TGT_ACC, ACC_VAL[8 * acc_i_q +: 8], 1'b0};
            acc_i_q <= acc_i_q + 3'h1;
        end
        else if (!dma_in.valid && dma_req.a)
        begin
            dma_in <= '{1'b1, TGT_A, hi_a_q ? A_VAL[15:8] : A_VAL[7:0], cut_a};
            hi_a_q <= ~hi_a_q;
        end
        else if (!dma_in.valid && dma_req.b)
        begin
            dma_in <= '{1'b1, TGT_B, hi_b_q ? B_VAL[15:8] : B_VAL[7:0], 1'b0};
            hi_b_q <= ~hi_b_q;
        end
        else
            dma_in <= '{1'b0, dma_in.tgt, ~dma_in.data, 1'b0};
    end
endmodule : mac_dma_model

// File: sim/test_multiply_accumulate_engine.sv
// Self-checking bench for the multiply-accumulate engine.
// Assumes the register port and the DMA stand-in model.
`timescale 1ns/1ps
module test_multiply_accumulate_engine;
    import mac_pkg::*;
    logic         core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic         dma_chan_en = 1'b0, seen_b, cut_a = 1'b0;
    logic [3:0]   reg_addr = 4'h0;
    logic [7:0]   reg_wdata = 8'h00, reg_rdata, rd_v;
    mac_dma_in_s  dma_in;
    mac_dma_req_s dma_req;
    int           failures = 0, n_checks = 0, cycles = 0;
    mac_engine i_mac_engine (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dma_chan_en(dma_chan_en), .dma_in(dma_in), .dma_req(dma_req));
    mac_dma_model i_mac_dma_model (.core_clk(core_clk), .sys_rst(sys_rst), .cut_a(cut_a),
        .dma_req(dma_req), .dma_in(dma_in));
    // ==========================================================
    // Bus tasks and comparison
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask : rd
    task automatic acc_chk(input logic [39:0] exp);
        logic [39:0] v;
        for (int i = 0; i < 5; i++)
        begin
            rd(OFS_ACC0 + 4'(i));
            v[8*i +: 8] = rd_v;
        end
        check(v, exp);
    endtask : acc_chk
    // Poll status until busy drops; rd_v keeps the last status read
    task automatic wait_idle();
        for (int n = 0; n < 40; n++)
        begin
            rd(OFS_STAT);
            if (rd_v[ST_BUSY] === 1'b0)
                break;
        end
    endtask : wait_idle
    // Load operands and config, start, compare the accumulator view
    task automatic op(input logic [15:0] a, b, input logic [7:0] cf, input logic [39:0] exp);
        wr(OFS_AL, a[7:0]);
        wr(OFS_AH, a[15:8]);
        wr(OFS_BL, b[7:0]);
        wr(OFS_BH, b[15:8]);
        wr(OFS_CFG0, cf);
        wr(OFS_STAT, 8'h80);
        acc_chk(exp);
    endtask : op
    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // ==========================================================
    // Clock and hang guard
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            wrap_up();
        end
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(OFS_CFG1);
        check(rd_v, CFG_RST);
        rd(4'hE);
        check(rd_v, 8'h00);
        wr(OFS_CFG0, 8'h20);
        op(16'h0003, 16'h0005, 8'h00, 40'h00_0000_000F);
        op(16'h0003, 16'h0005, 8'h00, 40'h00_0000_001E);
        rd(OFS_STAT);
        check(rd_v, 8'h18);
        op(16'h0003, 16'h0005, 8'h08, 40'h00_0000_000F);
        op(16'hFFFF, 16'h0002, 8'h0C, 40'hFF_FFFF_FFFE);
        wr(OFS_CFG1, 8'h04);
        acc_chk(40'hFF_FFFF_FFFF);
        wr(OFS_CFG1, 8'h01);
        acc_chk(40'h00_0000_0000);
        wr(OFS_CFG1, 8'h00);
        op(16'h4000, 16'h4000, 8'h18, 40'h00_2000_0000);
        wr(OFS_CFG0, 8'h20);
        rd(OFS_CFG0);
        check(rd_v, 8'h00);
        rd(OFS_STAT);
        check(rd_v, 8'h00);
        acc_chk(40'h0);
        op(16'h0000, 16'h0005, 8'h08, 40'h00_0000_0000);
        rd(OFS_STAT);
        check(rd_v, 8'h1C);
        // DMA mode: operands come from the stand-in model
        @(posedge core_clk);
        dma_chan_en <= 1'b1;
        wr(OFS_CFG0, 8'h08);
        wr(OFS_ITER, 8'h01);
        #1 check(dma_req, 3'b000);
        wr(OFS_STAT, 8'h80);
        wait_idle();
        check(rd_v, 8'h18);
        acc_chk(40'h00_0000_0006);
        wr(OFS_CFG2, 8'h01);
        wr(OFS_STAT, 8'h80);
        seen_b = 1'b0;
        repeat (8)
        begin
            @(posedge core_clk);
            #1 check(dma_req.a, 1'b0);
            seen_b = seen_b | dma_req.b;
        end
        check(seen_b, 1'b1);
        wait_idle();
        // Signed two-byte accumulator preload, then one accumulate step
        wr(OFS_CFG2, 8'h20);
        wr(OFS_CFG0, 8'h04);
        wr(OFS_STAT, 8'h80);
        wait_idle();
        check(rd_v, 8'h18);
        acc_chk(40'hFF_FFFF_8007);
        // First operand source runs dry after its low byte
        wr(OFS_CFG2, 8'h00);
        cut_a <= 1'b1;
        wr(OFS_STAT, 8'h80);
        wait_idle();
        check(rd_v, 8'h00);
        acc_chk(40'hFF_FFFF_8007);
        wrap_up();
    end
endmodule : test_multiply_accumulate_engine
